// ### rtl/switch_status_top.sv
// switch status register with AHB-Lite slave and interrupt on intx change
// assumes one clock hclk; hresetn is the fundamental reset; hot_reset_n
// is a synchronous hot reset pulse from the same clock domain
//
// Design decision made here: the AHB-Lite register port.
`default_nettype none
`include "switch_status_consts.svh"

module switch_status_top
    import switch_status_pkg::*;
(
    // clock and resets
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hot_reset_n,
    // strap pins
    input  wire logic [3:0]  operating_config_code,
    input  wire logic        common_clock_down_strap,
    input  wire logic        common_clock_up_strap,
    input  wire logic        master_serial_slow_strap,
    input  wire logic        port_a_lane_flip_strap,
    input  wire logic        port_b_lane_flip_strap,
    input  wire logic        port_c_lane_flip_strap,
    input  wire logic        ref_clock_select_strap,
    input  wire logic        hold_in_reset_strap,
    // aggregated legacy interrupt lines, same clock domain
    input  wire logic [3:0]  intx_state,
    // decoded mode flags
    output logic             mode_non_transparent,
    output logic             mode_failover,
    output logic             mode_eeprom_init,
    output logic             mode_reserved,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // interrupt
    output logic             irq
);

    localparam int NI = `SWITCH_STATUS_NUM_INTX;

    logic [`SWITCH_STATUS_STRAP_W-1:0] straps;
    logic [3:0]                mark_q;
    logic [3:0]                mark_d;
    logic [NI-1:0]             intx_q;
    logic [NI-1:0]             ist_q;
    logic [NI-1:0]             ist_d;
    logic [NI-1:0]             imask_q;
    logic [NI-1:0]             imask_d;
    logic [NI-1:0]             ev;
    switch_status_bus_type             st_q;
    switch_status_bus_type             st_d;
    logic [`SWITCH_STATUS_ADDR_W-1:0]  wad_q;
    logic [`SWITCH_STATUS_ADDR_W-1:0]  wad_d;
    logic [31:0]               rd_q;
    logic [31:0]               rd_d;
    logic [31:0]               status_word;
    logic                      acc;
    logic [`SWITCH_STATUS_ADDR_W-1:0]  a;
    logic                      wr_mark;
    logic                      wr_mask;
    logic                      rd_ist;

    ////////////////////////////////////////////////////////////////////////////
    // strap capture; pins are asynchronous so they pass the sync module
    switch_status_strap_sync #(
        .WIDTH (`SWITCH_STATUS_STRAP_W)
    ) u_sync (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .strap_pins   ({hold_in_reset_strap, ref_clock_select_strap,
                        port_c_lane_flip_strap, port_b_lane_flip_strap,
                        port_a_lane_flip_strap, master_serial_slow_strap,
                        common_clock_up_strap, common_clock_down_strap,
                        operating_config_code}),
        .strap_levels (straps)
    );

    // mode decode for the rest of the switch
    always_comb begin
        mode_non_transparent = 1'b0;
        mode_failover        = 1'b0;
        mode_eeprom_init     = 1'b0;
        mode_reserved        = 1'b0;
        case (straps[`SWITCH_STATUS_MODE_MSB:`SWITCH_STATUS_MODE_LSB])
            SWITCH_STATUS_MODE_NTB:           mode_non_transparent = 1'b1;
            SWITCH_STATUS_MODE_NTB_INIT: begin
                mode_non_transparent = 1'b1;
                mode_eeprom_init     = 1'b1;
            end
            SWITCH_STATUS_MODE_FAILOVER: begin
                mode_non_transparent = 1'b1;
                mode_failover        = 1'b1;
            end
            SWITCH_STATUS_MODE_FAILOVER_INIT: begin
                mode_non_transparent = 1'b1;
                mode_failover        = 1'b1;
                mode_eeprom_init     = 1'b1;
            end
            default:                  mode_reserved = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word assembly; unlisted bits stay zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`SWITCH_STATUS_MODE_MSB:`SWITCH_STATUS_MODE_LSB] = straps[3:0];
        status_word[`SWITCH_STATUS_CCLK_DN_BIT] = straps[4];
        status_word[`SWITCH_STATUS_CCLK_UP_BIT] = straps[5];
        status_word[`SWITCH_STATUS_MSLOW_BIT]   = straps[6];
        status_word[`SWITCH_STATUS_LFLIP_A_BIT] = straps[7];
        status_word[`SWITCH_STATUS_LFLIP_B_BIT] = straps[8];
        status_word[`SWITCH_STATUS_LFLIP_C_BIT] = straps[9];
        status_word[`SWITCH_STATUS_REFCLK_BIT]  = straps[10];
        status_word[`SWITCH_STATUS_HALT_BIT]    = straps[11];
        status_word[`SWITCH_STATUS_MARK_MSB:`SWITCH_STATUS_MARK_LSB] = mark_q;
        status_word[`SWITCH_STATUS_INTX_MSB:`SWITCH_STATUS_INTX_LSB] = intx_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states; writes land from the data phase
    assign acc = hsel && hready && htrans[1];
    assign a   = haddr[`SWITCH_STATUS_ADDR_W-1:0];
    assign wr_mark = (st_q == SWITCH_STATUS_WDATA) && (wad_q == `SWITCH_STATUS_OFF_STATUS);
    assign wr_mask = (st_q == SWITCH_STATUS_WDATA) && (wad_q == `SWITCH_STATUS_OFF_IRQ_MASK);
    assign rd_ist  = acc && !hwrite && (a == `SWITCH_STATUS_OFF_IRQ_STAT);

    always_comb begin
        st_d  = SWITCH_STATUS_IDLE;
        wad_d = wad_q;
        rd_d  = 32'h0000_0000;
        if (acc && hwrite) begin
            st_d  = SWITCH_STATUS_WDATA;
            wad_d = a;
        end
        if (acc && !hwrite) begin
            unique case (a)
                `SWITCH_STATUS_OFF_STATUS:   rd_d = status_word;
                `SWITCH_STATUS_OFF_IRQ_STAT: rd_d = {28'h0000000, ist_q};
                `SWITCH_STATUS_OFF_IRQ_MASK: rd_d = {28'h0000000, imask_q};
                default:             rd_d = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q  <= SWITCH_STATUS_IDLE;
            wad_q <= '0;
            rd_q  <= 32'h0000_0000;
        end else begin
            st_q  <= st_d;
            wad_q <= wad_d;
            rd_q  <= rd_d;
        end
    end

    assign hrdata    = rd_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // marker: only the fundamental reset clears it, hot reset leaves it alone
    always_comb begin
        mark_d = mark_q;
        if (wr_mark) begin
            mark_d = hwdata[`SWITCH_STATUS_MARK_MSB:`SWITCH_STATUS_MARK_LSB];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mark_q <= `SWITCH_STATUS_MARK_RST;
        end else begin
            mark_q <= mark_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: any change of an intx line is an event; read of irq status
    // clears, but an event in the clearing cycle still sets its bit
    assign ev = intx_state ^ intx_q;

    always_comb begin
        ist_d   = ist_q;
        imask_d = imask_q;
        if (rd_ist) begin
            ist_d = '0;
        end
        ist_d = ist_d | ev;
        if (wr_mask) begin
            imask_d = hwdata[NI-1:0];
        end
    end

    // hot reset clears interrupt state but never the marker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            intx_q  <= '0;
            ist_q   <= `SWITCH_STATUS_IRQ_RST;
            imask_q <= `SWITCH_STATUS_IRQ_RST;
        end else if (!hot_reset_n) begin
            intx_q  <= intx_state;
            ist_q   <= `SWITCH_STATUS_IRQ_RST;
            imask_q <= `SWITCH_STATUS_IRQ_RST;
        end else begin
            intx_q  <= intx_state;
            ist_q   <= ist_d;
            imask_q <= imask_d;
        end
    end

    assign irq = |(ist_q & imask_q);

endmodule

`default_nettype wire

// ### rtl/switch_status_consts.svh
// constants for the switch status register block
// assumes inclusion by bare name from the package and the modules
`ifndef SWITCH_STATUS_CONSTS_SVH
`define SWITCH_STATUS_CONSTS_SVH

// register byte offsets
`define SWITCH_STATUS_OFF_STATUS   12'h0a0
`define SWITCH_STATUS_OFF_IRQ_STAT 12'h0b0
`define SWITCH_STATUS_OFF_IRQ_MASK 12'h0b4
`define SWITCH_STATUS_ADDR_W       12

// status field positions
`define SWITCH_STATUS_MODE_LSB     0
`define SWITCH_STATUS_MODE_MSB     3
`define SWITCH_STATUS_CCLK_DN_BIT  4
`define SWITCH_STATUS_CCLK_UP_BIT  5
`define SWITCH_STATUS_MSLOW_BIT    6
`define SWITCH_STATUS_LFLIP_A_BIT  7
`define SWITCH_STATUS_LFLIP_B_BIT  8
`define SWITCH_STATUS_LFLIP_C_BIT  9
`define SWITCH_STATUS_REFCLK_BIT   10
`define SWITCH_STATUS_HALT_BIT     11
`define SWITCH_STATUS_MARK_LSB     13
`define SWITCH_STATUS_MARK_MSB     16
`define SWITCH_STATUS_INTX_LSB     20
`define SWITCH_STATUS_INTX_MSB     23

// reset values
`define SWITCH_STATUS_MARK_RST     4'h0
`define SWITCH_STATUS_IRQ_RST      4'h0

// strap field width (mode 4 + eight single straps)
`define SWITCH_STATUS_STRAP_W      12
`define SWITCH_STATUS_NUM_INTX     4

`endif

// ### rtl/switch_status_pkg.sv
// types for the switch status register block
// assumes the constants header sits beside it
`default_nettype none
`include "switch_status_consts.svh"

package switch_status_pkg;
    // operating mode codes as captured from the mode straps
    typedef enum logic [3:0] {
        SWITCH_STATUS_MODE_NTB          = 4'h2,
        SWITCH_STATUS_MODE_NTB_INIT     = 4'h3,
        SWITCH_STATUS_MODE_FAILOVER     = 4'h4,
        SWITCH_STATUS_MODE_FAILOVER_INIT = 4'h5
    } switch_status_mode_type;

    // bus slave states
    typedef enum logic [1:0] {
        SWITCH_STATUS_IDLE  = 2'b01,
        SWITCH_STATUS_WDATA = 2'b10
    } switch_status_bus_type;
endpackage

`default_nettype wire

// ### rtl/switch_status_strap_sync.sv
// two-flop synchroniser plus capture-at-release for the strap pins
// assumes straps are stable around the release of the fundamental reset
`default_nettype none
`include "switch_status_consts.svh"

module switch_status_strap_sync
    import switch_status_pkg::*;
#(
    parameter int WIDTH = `SWITCH_STATUS_STRAP_W
) (
    // clock and fundamental reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // raw pins and captured levels
    input  wire logic [WIDTH-1:0] strap_pins,
    output logic      [WIDTH-1:0] strap_levels
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] cap_q;
    logic [WIDTH-1:0] cap_d;
    logic [1:0]       age_q;
    logic [1:0]       age_d;

    ////////////////////////////////////////////////////////////////////////////
    // capture once the sync chain holds post-release values; resets cannot
    // load a port value, so capture happens on clocked edges after release
    always_comb begin
        age_d = age_q;
        cap_d = cap_q;
        if (age_q != 2'h3) begin
            age_d = age_q + 2'h1;
            cap_d = sync_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_q <= '0;
            cap_q  <= '0;
            age_q  <= 2'h0;
        end else begin
            meta_q <= strap_pins;
            sync_q <= meta_q;
            cap_q  <= cap_d;
            age_q  <= age_d;
        end
    end

    assign strap_levels = cap_q;

endmodule

`default_nettype wire

// ### dv/switch_status_chk.sv
// checker for the switch status block: bus answers, read data, mode flags
// assumes it is bound to switch_status_top and sees only its ports
`default_nettype none
`include "switch_status_consts.svh"

module switch_status_chk (
    // clock and resets
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hot_reset_n,
    // bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // outputs
    input wire logic        irq,
    input wire logic        mode_non_transparent,
    input wire logic        mode_failover,
    input wire logic        mode_eeprom_init,
    input wire logic        mode_reserved
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ////////////////////////////////////////////////////////////////////////
    // read requests taken and whether they hit a mapped word
    logic rd;
    logic rd_st;
    logic mapped;
    assign rd = hsel & hready & htrans[1] & ~hwrite;
    assign rd_st = rd & (haddr[11:0] == `SWITCH_STATUS_OFF_STATUS);
    assign mapped = haddr[11:0] inside {`SWITCH_STATUS_OFF_STATUS, `SWITCH_STATUS_OFF_IRQ_STAT, `SWITCH_STATUS_OFF_IRQ_MASK};
    ////////////////////////////////////////////////////////////////////////
    // properties; reserved bits are 12, 19:17 and 31:24
    property p_rsv; $past(rd_st) |-> (hrdata & 32'hff0e1000) == 32'h0; endproperty
    property p_idle; !$past(rd && mapped) |-> hrdata == 32'h0; endproperty
    property p_rdy; hreadyout; endproperty
    property p_okay; !hresp; endproperty
    property p_dec_rsv; mode_reserved != mode_non_transparent; endproperty
    property p_dec_fo; mode_failover |-> mode_non_transparent; endproperty
    property p_dec_ini; mode_eeprom_init |-> mode_non_transparent; endproperty
    property p_hot; !hot_reset_n |=> !irq; endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved status bits read nonzero");
    a_idle: assert property (p_idle)
        else $error("read data nonzero outside a mapped read");
    a_rdy: assert property (p_rdy)
        else $error("ready low");
    a_okay: assert property (p_okay)
        else $error("error response");
    a_dec_rsv: assert property (p_dec_rsv)
        else $error("reserved flag disagrees with mode");
    a_dec_fo: assert property (p_dec_fo)
        else $error("failover flag without non-transparent");
    a_dec_ini: assert property (p_dec_ini)
        else $error("init flag without non-transparent");
    a_hot: assert property (p_hot)
        else $error("interrupt high after hot reset");
    c_rd: cover property (rd_st);
    c_irq: cover property ($rose(irq));
    c_fo: cover property (mode_failover);
    c_hot: cover property (!hot_reset_n);
endmodule

bind switch_status_top switch_status_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hot_reset_n(hot_reset_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .mode_non_transparent(mode_non_transparent), .mode_failover(mode_failover),
    .mode_eeprom_init(mode_eeprom_init), .mode_reserved(mode_reserved));
`default_nettype wire

// ### dv/tb_top.sv
// self-checking bench for the switch status block
// assumes the design, its package and the checker are compiled first
`default_nettype none
`include "switch_status_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hot_n, hsel, hwrite, hreadyout, hresp, irq;
    logic        nt, fo, ini, rsv;
    logic [31:0] haddr, hwdata, hrdata, rd, w;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [11:0] st;
    logic [3:0]  intx;
    int          n_mismatch, n_tests, i;
    int          seed = 57078;

    // strap vector laid out in the same order as the status bits
    switch_status_top dut_u (.hclk(hclk), .hresetn(hresetn), .hot_reset_n(hot_n),
        .operating_config_code(st[3:0]), .common_clock_down_strap(st[4]),
        .common_clock_up_strap(st[5]), .master_serial_slow_strap(st[6]),
        .port_a_lane_flip_strap(st[7]), .port_b_lane_flip_strap(st[8]),
        .port_c_lane_flip_strap(st[9]), .ref_clock_select_strap(st[10]),
        .hold_in_reset_strap(st[11]), .intx_state(intx), .mode_non_transparent(nt),
        .mode_failover(fo), .mode_eeprom_init(ini), .mode_reserved(rsv), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    ////////////////////////////////////////////////////////////////////////
    // expectations: decode flags {nt, failover, init, reserved} and status word
    function automatic logic [3:0] flags(input logic [3:0] c);
        case (c)
            4'h2: flags = 4'b1000;
            4'h3: flags = 4'b1010;
            4'h4: flags = 4'b1100;
            4'h5: flags = 4'b1110;
            default: flags = 4'b0001;
        endcase
    endfunction
    function automatic logic [31:0] exp_st(input logic [11:0] s, input logic [3:0] m, x);
        exp_st = {8'h00, x, 3'b000, m, 1'b0, s};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one single word transfer; entered right after a rising edge
    task automatic xfer(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // straps held steady across the whole capture window
    task automatic fund_reset(input logic [11:0] s);
        hresetn <= 1'b0;
        st <= s;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    task automatic test_done;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        test_done();
    end

    // main sequence
    initial begin
        hresetn = 1'b0;
        hot_n = 1'b1;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'b00;
        hsize = 3'b010;
        st = 12'h000;
        intx = 4'h0;
        @(posedge hclk);
        // every mode code, random other straps, marker write with all bits random
        for (i = 0; i < 16; i++) begin
            fund_reset({8'($random(seed)), 4'(i)});
            xfer(1'b0, `SWITCH_STATUS_OFF_STATUS, 32'h0, rd);
            `CHK(rd, exp_st(st, 4'h0, intx))
            `CHK({nt, fo, ini, rsv}, flags(st[3:0]))
            w = $random(seed);
            xfer(1'b1, `SWITCH_STATUS_OFF_STATUS, w, rd);
            xfer(1'b0, `SWITCH_STATUS_OFF_STATUS, 32'h0, rd);
            `CHK(rd, exp_st(st, w[16:13], intx))
        end
        // interrupt lines shown one cycle late; hold them before reading
        for (i = 0; i < 8; i++) begin
            intx <= 4'($random(seed));
            repeat (3) @(posedge hclk);
            xfer(1'b0, `SWITCH_STATUS_OFF_STATUS, 32'h0, rd);
            `CHK(rd[23:20], intx)
        end
        // hot reset keeps the marker
        hot_n <= 1'b0;
        @(posedge hclk);
        hot_n <= 1'b1;
        @(posedge hclk);
        xfer(1'b0, `SWITCH_STATUS_OFF_STATUS, 32'h0, rd);
        `CHK(rd[16:13], w[16:13])
        // unmasked change raises the interrupt, an interrupt status read clears it
        xfer(1'b1, `SWITCH_STATUS_OFF_IRQ_MASK, 32'hf, rd);
        intx <= intx ^ 4'h1;
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b1)
        xfer(1'b0, `SWITCH_STATUS_OFF_IRQ_STAT, 32'h0, rd);
        `CHK(rd[3:0], 4'h1)
        @(posedge hclk);
        `CHK(irq, 1'b0)
        // masked change stays quiet but is still recorded
        xfer(1'b1, `SWITCH_STATUS_OFF_IRQ_MASK, 32'h0, rd);
        intx <= intx ^ 4'h2;
        repeat (3) @(posedge hclk);
        `CHK(irq, 1'b0)
        xfer(1'b0, `SWITCH_STATUS_OFF_IRQ_STAT, 32'h0, rd);
        `CHK(rd[3:0], 4'h2)
        // unmapped word reads zero
        xfer(1'b0, 32'h0a8, 32'h0, rd);
        `CHK(rd, 32'h0)
        test_done();
    end
endmodule
`default_nettype wire
